// File: hdl/csc_core.sv
// csc_core: system control instructions, cpu states and block move
// Behaviour
// - low-power op in active enters halt mode
// - low-power op in subactive goes watch/active
// - load flags from immediate or register
// - store flags copies flag byte to register
// - and/or/xor flags with immediate byte
// - no-operation only advances pc by two
// - return op resumes interrupted program
// - block move copies bytes until count zero
// - next instruction starts after final byte
// - three states: execute, halt, exception
// - execute sequentially, active or subactive clock
// - interrupt enters exception handling; reset goes straight to active
// - interrupt saves pc and flags via stack
// - bus cycle takes exactly two states
// - memory path sixteen bits, byte or word
// - peripheral path eight bits, bytes only
// - peripheral word write keeps upper byte
`default_nettype none
module csc_core (
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  // instruction port
  input  wire logic              i_op_valid,
  input  wire csc_pkg::csc_op_t  i_op,
  input  wire logic [7:0]        i_imm,
  input  wire logic [7:0]        i_reg_byte,
  output logic                   o_op_ready,
  output logic                   o_reg_we,
  output logic [7:0]             o_reg_wdata,
  // block move parameters and updates
  input  wire logic [7:0]        i_block_count_reg,
  input  wire logic [15:0]       i_source_pointer_reg,
  input  wire logic [15:0]       i_dest_pointer_reg,
  input  wire logic [15:0]       i_stack_pointer_reg,
  output logic [7:0]             o_block_count_reg,
  output logic [15:0]            o_source_pointer_reg,
  output logic [15:0]            o_dest_pointer_reg,
  output logic [15:0]            o_stack_pointer_reg,
  output logic                   o_move_regs_we,
  // mode control
  input  wire logic              i_subactive,
  input  wire logic [1:0]        i_halt_sel,
  input  wire logic              i_wake,
  input  wire logic              i_irq,
  input  wire logic [15:0]       i_irq_vector,
  output logic [3:0]             o_state,
  output logic                   o_halted,
  output logic                   o_sub_clock_sel,
  // program counter and flags
  output logic [15:0]            o_pc,
  output logic [7:0]             o_condition_code_reg,
  // bus towards memory and peripherals
  input  wire logic [15:0]       i_mem_rdata,
  input  wire logic [7:0]        i_per_rdata,
  output logic                   o_mem_en,
  output logic                   o_per_en,
  output logic                   o_bus_we,
  output logic [1:0]             o_bus_be,
  output logic [15:0]            o_bus_addr,
  output logic [15:0]            o_bus_wdata
);
  typedef struct packed {
    csc_pkg::csc_state_t st;
    csc_pkg::csc_state_t ret;  // mode to resume after exception
    logic [2:0]          step;
    logic [15:0]         pc;
    logic [7:0]          condition_code_reg;
    logic [7:0]          cnt;
    logic [15:0]         src;
    logic [15:0]         dst;
    logic [15:0]         sp;
    logic [15:0]         data;
    logic                req;
    logic                we;
    logic                word;
    logic [15:0]         addr;
    logic [15:0]         wdata;
    logic                rwe;
    logic [7:0]          rdat;
    logic                mwe;
  } csc_core_st_t;

  csc_core_st_t s_q;
  csc_core_st_t s_d;
  logic         bus_busy;
  logic         bus_done;
  logic [15:0]  bus_rdata;
  logic         exec_mode;
  logic         take_op;

  // ************************************************
  // bus cycle engine
  // ************************************************
  csc_bus_cycle u_bus (
    .i_clock     (i_clock),
    .i_rst_n     (i_rst_n),
    .i_ce        (i_ce),
    .i_req       (s_q.req),
    .i_we        (s_q.we),
    .i_word      (s_q.word),
    .i_addr      (s_q.addr),
    .i_wdata     (s_q.wdata),
    .i_mem_rdata (i_mem_rdata),
    .i_per_rdata (i_per_rdata),
    .o_busy      (bus_busy),
    .o_done      (bus_done),
    .o_rdata     (bus_rdata),
    .o_mem_en    (o_mem_en),
    .o_per_en    (o_per_en),
    .o_we        (o_bus_we),
    .o_be        (o_bus_be),
    .o_addr      (o_bus_addr),
    .o_wdata     (o_bus_wdata)
  );

  // executing modes accept instructions
  assign exec_mode = (s_q.st == csc_pkg::CSC_ST_ACTIVE) ||
                     (s_q.st == csc_pkg::CSC_ST_SUBACT);
  assign take_op   = exec_mode && i_op_valid && !i_irq;

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    s_d      = s_q;
    s_d.req  = 1'b0;
    s_d.rwe  = 1'b0;
    s_d.mwe  = 1'b0;
    case (s_q.st)
      csc_pkg::CSC_ST_ACTIVE,
      csc_pkg::CSC_ST_SUBACT: begin
        if (exec_mode && i_irq) begin
          // interrupt: stack pc then flags
          s_d.ret  = s_q.st;
          s_d.st   = csc_pkg::CSC_ST_EXC;
          s_d.step = 3'h0;
          s_d.sp   = i_stack_pointer_reg;
        end else if (take_op) begin
          s_d.pc = s_q.pc + csc_pkg::CSC_PC_STEP;
          case (i_op)
            csc_pkg::CSC_OP_NOP: ;  // only pc moves
            csc_pkg::CSC_OP_LDI: s_d.condition_code_reg = i_imm;
            csc_pkg::CSC_OP_LDR: s_d.condition_code_reg = i_reg_byte;
            csc_pkg::CSC_OP_STF: begin
              s_d.rwe  = 1'b1;
              s_d.rdat = s_q.condition_code_reg;
            end
            csc_pkg::CSC_OP_ANDF: s_d.condition_code_reg = s_q.condition_code_reg & i_imm;
            csc_pkg::CSC_OP_ORF:  s_d.condition_code_reg = s_q.condition_code_reg | i_imm;
            csc_pkg::CSC_OP_XORF: s_d.condition_code_reg = s_q.condition_code_reg ^ i_imm;
            csc_pkg::CSC_OP_RTE: begin
              s_d.st   = csc_pkg::CSC_ST_RTE;
              s_d.step = 3'h0;
              s_d.sp   = i_stack_pointer_reg;
            end
            csc_pkg::CSC_OP_LOWP: begin
              if (s_q.st == csc_pkg::CSC_ST_ACTIVE) begin
                // halt mode from outside selection
                case (i_halt_sel)
                  csc_pkg::CSC_HALT_SLEEP:   s_d.st = csc_pkg::CSC_ST_SLEEP;
                  csc_pkg::CSC_HALT_STANDBY: s_d.st = csc_pkg::CSC_ST_STANDBY;
                  default:                   s_d.st = csc_pkg::CSC_ST_WATCH;
                endcase
              end else begin
                s_d.st = csc_pkg::CSC_ST_WATCH;
              end
            end
            csc_pkg::CSC_OP_BMOVE: begin
              if (i_block_count_reg != 8'h00) begin
                s_d.st   = csc_pkg::CSC_ST_MOVE;
                s_d.step = 3'h0;
                s_d.cnt  = i_block_count_reg;
                s_d.src  = i_source_pointer_reg;
                s_d.dst  = i_dest_pointer_reg;
              end
            end
            default: ;
          endcase
        end
      end
      csc_pkg::CSC_ST_SLEEP,
      csc_pkg::CSC_ST_STANDBY,
      csc_pkg::CSC_ST_WATCH: begin
        // wake returns to execution; sub may leave via watch to active
        if (i_wake || i_irq) begin
          if (s_q.st == csc_pkg::CSC_ST_WATCH && i_subactive &&
              i_halt_sel != csc_pkg::CSC_HALT_TOACT) begin
            s_d.st = csc_pkg::CSC_ST_SUBACT;
          end else begin
            s_d.st = csc_pkg::CSC_ST_ACTIVE;
          end
        end
      end
      csc_pkg::CSC_ST_EXC: begin
        // push pc word, push flags word, then load pc from i_irq_vector
        case (s_q.step)
          3'h0: begin
            s_d.sp    = s_q.sp - csc_pkg::CSC_PC_STEP;
            s_d.req   = 1'b1;
            s_d.we    = 1'b1;
            s_d.word  = 1'b1;
            s_d.addr  = s_q.sp - csc_pkg::CSC_PC_STEP;
            s_d.wdata = s_q.pc;
            s_d.step  = 3'h1;
          end
          3'h1: if (bus_done) begin
            s_d.sp    = s_q.sp - csc_pkg::CSC_PC_STEP;
            s_d.req   = 1'b1;
            s_d.addr  = s_q.sp - csc_pkg::CSC_PC_STEP;
            s_d.wdata = {s_q.condition_code_reg, s_q.condition_code_reg};
            s_d.step  = 3'h2;
          end
          3'h2: if (bus_done) begin
            s_d.pc  = i_irq_vector;
            s_d.condition_code_reg = s_q.condition_code_reg | csc_pkg::CSC_CCR_RESET;
            s_d.mwe = 1'b1;
            s_d.st  = s_q.ret;
          end
          default: s_d.step = 3'h0;
        endcase
      end
      csc_pkg::CSC_ST_RTE: begin
        // pop flags then pc
        case (s_q.step)
          3'h0: begin
            s_d.req  = 1'b1;
            s_d.we   = 1'b0;
            s_d.word = 1'b1;
            s_d.addr = s_q.sp;
            s_d.step = 3'h1;
          end
          3'h1: if (bus_done) begin
            s_d.condition_code_reg  = bus_rdata[15:8];
            s_d.req  = 1'b1;
            s_d.addr = s_q.sp + csc_pkg::CSC_PC_STEP;
            s_d.sp   = s_q.sp + csc_pkg::CSC_PC_STEP;
            s_d.step = 3'h2;
          end
          3'h2: if (bus_done) begin
            s_d.pc  = bus_rdata;
            s_d.sp  = s_q.sp + csc_pkg::CSC_PC_STEP;
            s_d.mwe = 1'b1;
            s_d.st  = i_subactive ? csc_pkg::CSC_ST_SUBACT
                                  : csc_pkg::CSC_ST_ACTIVE;
          end
          default: s_d.step = 3'h0;
        endcase
      end
      csc_pkg::CSC_ST_MOVE: begin
        // byte read then byte write; no fetch meanwhile
        case (s_q.step)
          3'h0: begin
            s_d.req  = 1'b1;
            s_d.we   = 1'b0;
            s_d.word = 1'b0;
            s_d.addr = s_q.src;
            s_d.step = 3'h1;
          end
          3'h1: if (bus_done) begin
            s_d.req   = 1'b1;
            s_d.we    = 1'b1;
            s_d.addr  = s_q.dst;
            s_d.wdata = {8'h00, bus_rdata[7:0]};
            s_d.step  = 3'h2;
          end
          3'h2: if (bus_done) begin
            s_d.src = s_q.src + 16'h0001;
            s_d.dst = s_q.dst + 16'h0001;
            s_d.cnt = s_q.cnt - 8'h01;
            s_d.mwe = 1'b1;
            s_d.step = 3'h0;
            if (s_q.cnt == 8'h01) begin
              // resume right after last byte
              s_d.st = i_subactive ? csc_pkg::CSC_ST_SUBACT
                                   : csc_pkg::CSC_ST_ACTIVE;
            end
          end
          default: s_d.step = 3'h0;
        endcase
      end
      default: s_d.st = csc_pkg::CSC_ST_ACTIVE;
    endcase
  end

  // ************************************************
  // state register, reset enters active directly with reset pc and flags
  // ************************************************
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q     <= '0;
      s_q.condition_code_reg <= csc_pkg::CSC_CCR_RESET;
      s_q.pc  <= csc_pkg::CSC_PC_RESET;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  // outputs
  assign o_op_ready = take_op;
  assign o_reg_we   = s_q.rwe;
  assign o_reg_wdata = s_q.rdat;
  assign o_block_count_reg    = s_q.cnt;
  assign o_source_pointer_reg = s_q.src;
  assign o_dest_pointer_reg   = s_q.dst;
  assign o_stack_pointer_reg  = s_q.sp;
  assign o_move_regs_we       = s_q.mwe;
  assign o_state    = s_q.st;
  assign o_halted   = (s_q.st == csc_pkg::CSC_ST_SLEEP) ||
                      (s_q.st == csc_pkg::CSC_ST_STANDBY) ||
                      (s_q.st == csc_pkg::CSC_ST_WATCH);
  assign o_sub_clock_sel = (s_q.st == csc_pkg::CSC_ST_SUBACT);
  assign o_pc = s_q.pc;
  assign o_condition_code_reg = s_q.condition_code_reg;

  // ************************************************
  // checks
  // ************************************************
  a_nop_pc: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && take_op && i_op == csc_pkg::CSC_OP_NOP) |=>
      (s_q.pc == $past(s_q.pc) + 16'h0002 &&
       s_q.condition_code_reg == $past(s_q.condition_code_reg)))
    else $error("no-operation changed more than pc");
  a_and_flags: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && take_op && i_op == csc_pkg::CSC_OP_ANDF) |=>
      s_q.condition_code_reg == ($past(s_q.condition_code_reg) & $past(i_imm)))
    else $error("and-flags result wrong");
  a_xor_flags: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && take_op && i_op == csc_pkg::CSC_OP_XORF) |=>
      s_q.condition_code_reg == ($past(s_q.condition_code_reg) ^ $past(i_imm)))
    else $error("xor-flags result wrong");
  a_load_flags: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && take_op && i_op == csc_pkg::CSC_OP_LDR) |=>
      s_q.condition_code_reg == $past(i_reg_byte))
    else $error("load-flags from register wrong");
  a_store_flags: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && take_op && i_op == csc_pkg::CSC_OP_STF) |=>
      (o_reg_we && o_reg_wdata == $past(s_q.condition_code_reg)))
    else $error("store-flags did not copy flags");
  a_lowp_halt: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && take_op && i_op == csc_pkg::CSC_OP_LOWP &&
     s_q.st == csc_pkg::CSC_ST_ACTIVE) |=> o_halted)
    else $error("low-power op did not halt");
  a_sub_watch: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && take_op && i_op == csc_pkg::CSC_OP_LOWP &&
     s_q.st == csc_pkg::CSC_ST_SUBACT) |=>
      s_q.st == csc_pkg::CSC_ST_WATCH)
    else $error("subactive low-power op missed watch");
  a_zero_move: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && take_op && i_op == csc_pkg::CSC_OP_BMOVE &&
     i_block_count_reg == 8'h00) |=> exec_mode)
    else $error("zero count block move did work");
  a_move_nofetch: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    s_q.st == csc_pkg::CSC_ST_MOVE |-> !o_op_ready)
    else $error("fetch accepted during block move");
endmodule
`default_nettype wire

// File: hdl/csc_pkg.sv
// csc_pkg: constants and types for the system control core
`default_nettype none
package csc_pkg;
  // ************************************************
  // operation codes presented to the core
  // ************************************************
  typedef enum logic [3:0] {
    CSC_OP_NONE  = 4'h0,
    CSC_OP_NOP   = 4'h1,
    CSC_OP_LDI   = 4'h2,  // load flags from immediate
    CSC_OP_LDR   = 4'h3,  // load flags from register
    CSC_OP_STF   = 4'h4,
    CSC_OP_ANDF  = 4'h5,
    CSC_OP_ORF   = 4'h6,
    CSC_OP_XORF  = 4'h7,
    CSC_OP_RTE   = 4'h8,
    CSC_OP_LOWP  = 4'h9,
    CSC_OP_BMOVE = 4'ha
  } csc_op_t;

  // ************************************************
  // cpu states and modes
  // ************************************************
  typedef enum logic [3:0] {
    CSC_ST_ACTIVE  = 4'h0,
    CSC_ST_SUBACT  = 4'h1,
    CSC_ST_SLEEP   = 4'h2,
    CSC_ST_STANDBY = 4'h3,
    CSC_ST_WATCH   = 4'h4,
    CSC_ST_EXC     = 4'h5,
    CSC_ST_RTE     = 4'h6,
    CSC_ST_MOVE    = 4'h7
  } csc_state_t;

  // halt selection supplied from outside
  localparam logic [1:0] CSC_HALT_SLEEP   = 2'h0;
  localparam logic [1:0] CSC_HALT_STANDBY = 2'h1;
  localparam logic [1:0] CSC_HALT_WATCH   = 2'h2;
  localparam logic [1:0] CSC_HALT_TOACT   = 2'h3;  // sub: via watch to active

  localparam logic [15:0] CSC_PC_STEP     = 16'h0002;
  localparam logic [7:0]  CSC_CCR_RESET   = 8'h80;  // interrupt mask set
  localparam logic [15:0] CSC_PC_RESET    = 16'h0000;
  localparam logic [15:0] CSC_PERIPH_BASE = 16'hff00;
  localparam logic [1:0]  CSC_BUS_STATES  = 2'h2;
endpackage
`default_nettype wire

// File: hdl/csc_bus_cycle.sv
// csc_bus_cycle: two-state bus cycle engine for memory and peripherals
`default_nettype none
module csc_bus_cycle (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic        i_word,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [15:0] i_mem_rdata,
  input  wire logic [7:0]  i_per_rdata,
  output logic             o_busy,
  output logic             o_done,
  output logic [15:0]      o_rdata,
  output logic             o_mem_en,
  output logic             o_per_en,
  output logic             o_we,
  output logic [1:0]       o_be,
  output logic [15:0]      o_addr,
  output logic [15:0]      o_wdata
);
  typedef struct packed {
    logic        act;
    logic        ph;
    logic        we;
    logic        word;
    logic        per;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        done;
  } csc_bus_st_t;

  csc_bus_st_t s_q;
  csc_bus_st_t s_d;
  logic        per_hit;

  // ************************************************
  // next state: T1 drives address, T2 returns data
  // ************************************************
  always_comb begin
    s_d     = s_q;
    per_hit = i_addr >= csc_pkg::CSC_PERIPH_BASE;
    s_d.done = 1'b0;
    if (!s_q.act && i_req) begin
      s_d.act  = 1'b1;
      s_d.ph   = 1'b0;
      s_d.we   = i_we;
      s_d.word = i_word & ~per_hit;  // peripherals byte only
      s_d.per  = per_hit;
      s_d.addr = i_addr;
      // word write to peripheral keeps only upper byte
      s_d.wdata = (per_hit && i_word) ? {8'h00, i_wdata[15:8]} : i_wdata;
    end else if (s_q.act && !s_q.ph) begin
      s_d.ph = 1'b1;
    end else if (s_q.act) begin
      s_d.act  = 1'b0;
      s_d.done = 1'b1;  // two states per cycle
      if (s_q.per) begin
        s_d.rdata = {i_per_rdata, 8'h00};
        if (!i_word) s_d.rdata = {8'h00, i_per_rdata};
      end else begin
        s_d.rdata = i_mem_rdata;  // 16-bit path
      end
    end
  end

  // state register
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_busy   = s_q.act;
  assign o_done   = s_q.done;
  assign o_rdata  = s_q.rdata;
  assign o_mem_en = s_q.act & ~s_q.per;
  assign o_per_en = s_q.act & s_q.per;
  assign o_we     = s_q.act & s_q.we;
  assign o_be     = !s_q.act ? 2'h0 : (s_q.word ? 2'h3 : 2'h1);
  assign o_addr   = s_q.addr;
  assign o_wdata  = s_q.wdata;

  a_cycle_two: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && !s_q.act && i_req) ##1 i_ce [*2] |=> o_done)
    else $error("bus cycle did not end after two states");
  a_per_byte: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_per_en |-> o_be != 2'h3)
    else $error("word access on peripheral path");
endmodule
`default_nettype wire

// File: dv/csc_mem_model.sv
// csc_mem_model: memory and peripheral model facing the core bus
`default_nettype none
module csc_mem_model (
  input  wire logic        i_clock,
  input  wire logic        i_mem_en,
  input  wire logic        i_per_en,
  input  wire logic        i_we,
  input  wire logic [1:0]  i_be,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_mem_rdata,
  output logic      [7:0]  o_per_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:65535];
  logic [15:0] junk_q = 16'h5a5a;
  // store on each state of a write, words high byte first
  always @(posedge i_clock) begin
    junk_q <= ~junk_q;
    if (i_mem_en && i_we && i_be == 2'h3) begin
      mem[i_addr]         <= i_wdata[15:8];
      mem[i_addr + 16'h1] <= i_wdata[7:0];
    end else if ((i_mem_en || i_per_en) && i_we) begin
      mem[i_addr] <= i_wdata[7:0];
    end
  end
  // lanes not selected carry a toggling pattern
  always_comb begin
    o_mem_rdata = junk_q;
    o_per_rdata = junk_q[7:0];
    if (i_mem_en && i_be == 2'h3) begin
      o_mem_rdata = {mem[i_addr], mem[i_addr + 16'h1]};
    end else if (i_mem_en) begin
      o_mem_rdata = {junk_q[15:8], mem[i_addr]};
    end
    if (i_per_en) begin
      o_per_rdata = mem[i_addr];
    end
  end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// testbench: self-checking bench for the system control core
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************
  // signals, instances and clock
  // ************************************************
  logic             i_clock = 1'b0;
  logic             i_rst_n = 1'b0;
  logic             i_ce, i_op_valid, i_subactive, i_wake, i_irq;
  csc_pkg::csc_op_t i_op;
  logic [7:0]       i_imm, i_reg_byte, i_block_count_reg, i_per_rdata;
  logic [15:0]      i_source_pointer_reg, i_dest_pointer_reg, i_irq_vector;
  logic [15:0]      i_stack_pointer_reg, i_mem_rdata, exp_pc, r;
  logic [1:0]       i_halt_sel, o_bus_be;
  logic             o_op_ready, o_reg_we, o_move_regs_we, o_halted;
  logic             o_sub_clock_sel, o_mem_en, o_per_en, o_bus_we;
  logic [7:0]       o_reg_wdata, o_block_count_reg, o_condition_code_reg;
  logic [15:0]      o_source_pointer_reg, o_dest_pointer_reg, o_pc;
  logic [15:0]      o_stack_pointer_reg, o_bus_addr, o_bus_wdata;
  logic [3:0]       o_state;
  logic [7:0]       exp_ccr;
  logic [7:0]       reg_q[$];
  logic [39:0]      move_q[$];
  int               n_errors, check_count, cyc, run;
  int               seed = 27;
  bit               in_irq;
  wire logic [39:0] move_seen = {o_block_count_reg, o_source_pointer_reg,
                                 o_dest_pointer_reg};
  csc_pkg::csc_op_t fops[7] = '{csc_pkg::CSC_OP_LDI, csc_pkg::CSC_OP_LDR,
    csc_pkg::CSC_OP_STF, csc_pkg::CSC_OP_ANDF, csc_pkg::CSC_OP_ORF,
    csc_pkg::CSC_OP_XORF, csc_pkg::CSC_OP_NOP};
  logic [1:0]       hsel[5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
  logic [3:0]       hst[4] = '{csc_pkg::CSC_ST_SLEEP, csc_pkg::CSC_ST_STANDBY,
    csc_pkg::CSC_ST_WATCH, csc_pkg::CSC_ST_WATCH};

  csc_core i_csc_core (.*);
  csc_mem_model i_csc_mem_model (.i_clock(i_clock), .i_mem_en(o_mem_en),
    .i_per_en(o_per_en), .i_we(o_bus_we), .i_be(o_bus_be),
    .i_addr(o_bus_addr), .i_wdata(o_bus_wdata),
    .o_mem_rdata(i_mem_rdata), .o_per_rdata(i_per_rdata));

  // 40 MHz clock
  always #12.5 i_clock = ~i_clock;

  task automatic chk(input string nm, input logic [39:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // offer one op, hold it until taken, release after the edge
  task automatic do_op(input csc_pkg::csc_op_t op, input logic [7:0] imm);
    int n;
    n = 0;
    @(negedge i_clock);
    i_op = op;
    i_imm = imm;
    i_op_valid = 1'b1;
    #1;
    while (o_op_ready !== 1'b1 && n < 40) begin
      @(negedge i_clock);
      #1;
      n++;
    end
    chk("op_taken", o_op_ready, 1'b1);
    @(negedge i_clock);
    i_op_valid = 1'b0;
  endtask

  // bounded wait for a state; no op taken while moving
  task automatic wait_st(input logic [3:0] st, input int lim);
    int n;
    n = 0;
    while (o_state !== st && n < lim) begin
      if (o_state === csc_pkg::CSC_ST_MOVE) chk("busy", o_op_ready, 0);
      @(negedge i_clock);
      n++;
    end
    chk("state", o_state, st);
  endtask

  task automatic bmove(input logic [7:0] cnt, input logic [15:0] src, dst);
    logic [7:0]  e[$];
    logic [15:0] a;
    for (int i = 0; i <= cnt; i++) begin
      a = (i < cnt) ? src + 16'(i) : dst + 16'(i);
      e.push_back(i_csc_mem_model.mem[a]);
    end
    for (int i = 0; i < cnt; i++)
      move_q.push_back({8'(cnt - 8'(i + 1)), src + 16'(i + 1),
                        dst + 16'(i + 1)});
    i_block_count_reg = cnt;
    i_source_pointer_reg = src;
    i_dest_pointer_reg = dst;
    exp_pc += 16'h2;
    do_op(csc_pkg::CSC_OP_BMOVE, 8'h00);
    wait_st(csc_pkg::CSC_ST_ACTIVE, 12 * cnt + 12);
    chk("pc", o_pc, exp_pc);
    for (int i = 0; i <= cnt; i++) begin
      a = dst + 16'(i);
      chk("dst_byte", i_csc_mem_model.mem[a], e[i]);
    end
  endtask

  // cycle limit, bus cycle length and queued result checks
  always @(negedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
    if (o_mem_en === 1'b1 || o_per_en === 1'b1) run++;
    else if (run != 0) begin
      chk("bus_states", 40'(run), 40'h2);
      run = 0;
    end
    if (o_per_en === 1'b1) chk("per_be", o_bus_be, 2'h1);
    if (o_reg_we === 1'b1) chk("reg_wdata", o_reg_wdata, reg_q.pop_front());
    if (o_move_regs_we === 1'b1)
      chk("move_regs", in_irq ? {24'h0, o_stack_pointer_reg} : move_seen,
          move_q.pop_front());
  end

  // main sequence
  initial begin
    {i_ce, i_op_valid, i_subactive, i_wake, i_irq} = 5'h10;
    {i_imm, i_reg_byte, i_block_count_reg, i_halt_sel} = 26'h0;
    {i_source_pointer_reg, i_dest_pointer_reg} = 32'h0;
    {i_stack_pointer_reg, i_irq_vector} = 32'h0;
    i_op = csc_pkg::CSC_OP_NONE;
    exp_ccr = 8'h80;
    exp_pc = 16'h0000;
    for (int a = 0; a < 65536; a++) i_csc_mem_model.mem[a] = 8'($random(seed));
    repeat (12) @(negedge i_clock);
    chk("rst_state", o_state, csc_pkg::CSC_ST_ACTIVE);
    chk("rst_flags", {o_pc, o_condition_code_reg}, 24'h000080);
    i_rst_n = 1'b1;
    for (int k = 0; k < 21; k++) begin
      r = 16'($random(seed));
      i_reg_byte = r[15:8];
      case (fops[k % 7])
        csc_pkg::CSC_OP_LDI: exp_ccr = r[7:0];
        csc_pkg::CSC_OP_LDR: exp_ccr = r[15:8];
        csc_pkg::CSC_OP_STF: reg_q.push_back(exp_ccr);
        csc_pkg::CSC_OP_ANDF: exp_ccr &= r[7:0];
        csc_pkg::CSC_OP_ORF: exp_ccr |= r[7:0];
        csc_pkg::CSC_OP_XORF: exp_ccr ^= r[7:0];
        default: ;
      endcase
      exp_pc += 16'h2;
      do_op(fops[k % 7], r[7:0]);
      chk("ccr", o_condition_code_reg, exp_ccr);
      chk("pc", o_pc, exp_pc);
    end
    bmove(8'h03, 16'h0100, 16'h0300);
    bmove(8'h00, 16'h0100, 16'h0310);
    bmove(8'h02, 16'h0120, 16'hff10);
    bmove(8'h02, 16'h0130, 16'hfffd);  // last byte one below top
    for (int m = 0; m < 5; m++) begin
      i_halt_sel = hsel[m];
      if (m == 3) begin
        i_subactive = 1'b1;
        wait_st(csc_pkg::CSC_ST_SUBACT, 8);
        chk("sub_clk", o_sub_clock_sel, 1'b1);
      end
      exp_pc += 16'h2;
      do_op(csc_pkg::CSC_OP_LOWP, 8'h00);
      if (m < 4) wait_st(hst[m], 8);
      if (m < 4) chk("halted", o_halted, 1'b1);
      if (m == 2) i_subactive = 1'b1;
      i_wake = 1'b1;
      wait_st((m == 2 || m == 3) ? csc_pkg::CSC_ST_SUBACT
                                 : csc_pkg::CSC_ST_ACTIVE, 20);
      @(negedge i_clock);
      i_wake = 1'b0;
      if (m == 4) i_subactive = 1'b0;
      chk("pc", o_pc, exp_pc);
    end
    exp_pc += 16'h2;
    do_op(csc_pkg::CSC_OP_LDI, 8'h15);
    i_stack_pointer_reg = 16'h0400;
    i_irq_vector = 16'h0200;
    in_irq = 1'b1;
    move_q.push_back(40'h03fc);  // stack after two pushes
    i_irq = 1'b1;
    wait_st(csc_pkg::CSC_ST_EXC, 8);
    i_irq = 1'b0;
    wait_st(csc_pkg::CSC_ST_ACTIVE, 40);
    chk("irq", {o_pc, o_condition_code_reg}, 24'h020095);
    r = {i_csc_mem_model.mem[16'h03fe], i_csc_mem_model.mem[16'h03ff]};
    chk("pushed_pc", r, exp_pc);
    do_op(csc_pkg::CSC_OP_LDI, 8'h2a);
    i_stack_pointer_reg = 16'h03fc;
    move_q.push_back(40'h0400);  // stack after two pops
    do_op(csc_pkg::CSC_OP_RTE, 8'h00);
    wait_st(csc_pkg::CSC_ST_ACTIVE, 40);
    chk("resume", {o_pc, o_condition_code_reg}, {exp_pc, 8'h15});
    repeat (4) @(negedge i_clock);
    chk("queues", reg_q.size() + move_q.size(), 0);
    print_verdict();
  end
endmodule
`default_nettype wire
